// file: axr_pkg.sv
// Notes on behaviour
// - Move-to is opcode 05, sub-op 00 in bits 21-25; index bits 6-10, source 11-15.
// - Nonzero privilege traps instead of writing; index above 6 is not written.
// - A narrow auxiliary register keeps only the low n bits of the source.
// - Configuration bit 31 enables the instruction cache.
// - Configuration bit 30 enables the data cache.
// - Configuration bit 29 permits burst writes on the external bus.
// - Configuration bit 28 selects byte order: clear big, set little endian.
// - Configuration bit 27 enables trap step; bits 26 and 25 are reserved.
// - Writing one to configuration bit 24 puts the processor to sleep.
// - Configuration bit 23 selects zero or one multiplier wait state.
// - Configuration bits 22 to 19 freeze instruction cache quarters one to four.
// - Reset clears all thirteen configuration bits and the status word.
// - Index 2 is the timer; 3 and 4 the non-cacheable window offset and mask.
// - Indexes 5 and 6 are the write-through window offset and mask.
// - Index 7 holds the program counter copy, outside the write range.
// - The read instruction returns narrow registers zero-extended in the low bits.
package axr_pkg;

  // ***************************************************************
  // Instruction fields (bit 0 of the word is the MSB in the ISA)
  // ***************************************************************
  localparam int          AXR_OPC_MSB    = 31;
  localparam int          AXR_OPC_LSB    = 26;
  localparam int          AXR_IDX_MSB    = 25;
  localparam int          AXR_IDX_LSB    = 21;
  localparam int          AXR_SRC_MSB    = 20;
  localparam int          AXR_SRC_LSB    = 16;
  localparam int          AXR_SUB_MSB    = 10;
  localparam int          AXR_SUB_LSB    = 6;
  localparam int          AXR_DST_MSB    = 4;
  localparam int          AXR_DST_LSB    = 0;
  localparam logic [5:0]  AXR_OPC_DIAG   = 6'h05;
  localparam logic [4:0]  AXR_SUB_MOVE_TO   = 5'h00;
  localparam logic [4:0]  AXR_SUB_MOVE_FROM = 5'h01;
  localparam logic [4:0]  AXR_IDX_WR_MAX = 5'h06;
  localparam logic [4:0]  AXR_IDX_RD_MAX = 5'h07;

  // ***************************************************************
  // Auxiliary register indexes
  // ***************************************************************
  localparam logic [2:0]  AXR_IDX_CFG    = 3'h0;
  localparam logic [2:0]  AXR_IDX_PSW    = 3'h1;
  localparam logic [2:0]  AXR_IDX_TMR    = 3'h2;
  localparam logic [2:0]  AXR_IDX_NCO    = 3'h3;
  localparam logic [2:0]  AXR_IDX_NCM    = 3'h4;
  localparam logic [2:0]  AXR_IDX_WTO    = 3'h5;
  localparam logic [2:0]  AXR_IDX_WTM    = 3'h6;
  localparam logic [2:0]  AXR_IDX_PCC    = 3'h7;

  // ***************************************************************
  // Configuration field positions (ISA bit 31 is word bit 0)
  // ***************************************************************
  localparam int          AXR_CFG_W      = 13;
  localparam int          AXR_CFG_ICACHE = 0;
  localparam int          AXR_CFG_DCACHE = 1;
  localparam int          AXR_CFG_BURST  = 2;
  localparam int          AXR_CFG_ENDIAN = 3;
  localparam int          AXR_CFG_TSTEP  = 4;
  localparam int          AXR_CFG_RSV0   = 5;
  localparam int          AXR_CFG_RSV1   = 6;
  localparam int          AXR_CFG_SLEEP  = 7;
  localparam int          AXR_CFG_MWAIT  = 8;
  localparam int          AXR_CFG_FRZ_LSB = 9;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [12:0] AXR_CFG_RST    = 13'h0000;
  localparam logic [31:0] AXR_PSW_RST    = 32'h00000000;
  localparam logic [31:0] AXR_WIN_RST    = 32'h00000000;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [1:0] {
    AXR_ST_IDLE  = 2'b01,
    AXR_ST_FETCH = 2'b10
  } axr_state_e;

  typedef struct packed {
    axr_state_e    st;
    logic          ready;
    logic          done;
    logic          trap;
    logic [4:0]    src;
    logic [2:0]    idx;
    logic          wen;
    logic [4:0]    waddr;
    logic [31:0]   wdata;
    logic [12:0]   cfg;
    logic          sleep;
    logic [31:0]   processor_status_word;
    logic [31:0]   tmr;
    logic          tload;
    logic [31:0]   nco;
    logic [31:0]   ncm;
    logic [31:0]   wto;
    logic [31:0]   wtm;
    logic [31:0]   pcc;
  } axr_regs_s;

  // Low bits of a word into the configuration width
  function automatic logic [12:0] axr_cfg_fit(input logic [31:0] w);
    axr_cfg_fit = w[AXR_CFG_W-1:0];
  endfunction

  // Configuration back to a word, upper bits zero
  function automatic logic [31:0] axr_cfg_wide(input logic [12:0] c);
    axr_cfg_wide = {19'h00000, c};
  endfunction

endpackage

// file: axr_decode.sv
`timescale 1ns/1ps
module axr_decode (
  input  wire logic [31:0] instr,
  output logic             is_move_to,
  output logic             is_move_from,
  output logic [4:0]       aux_idx,
  output logic [4:0]       gr_src,
  output logic [4:0]       gr_dst,
  output logic             wr_idx_ok,
  output logic             rd_idx_ok
);
  import axr_pkg::*;

  logic is_diag;

  always_comb begin
    is_diag      = instr[AXR_OPC_MSB:AXR_OPC_LSB] == AXR_OPC_DIAG;
    is_move_to   = is_diag && (instr[AXR_SUB_MSB:AXR_SUB_LSB] == AXR_SUB_MOVE_TO);
    is_move_from = is_diag && (instr[AXR_SUB_MSB:AXR_SUB_LSB] == AXR_SUB_MOVE_FROM);
    aux_idx      = instr[AXR_IDX_MSB:AXR_IDX_LSB];
    gr_src       = instr[AXR_SRC_MSB:AXR_SRC_LSB];
    gr_dst       = instr[AXR_DST_MSB:AXR_DST_LSB];
    // Undefined targets are simply dropped rather than trapped
    wr_idx_ok    = aux_idx <= AXR_IDX_WR_MAX;
    rd_idx_ok    = aux_idx <= AXR_IDX_RD_MAX;
  end
endmodule

// file: axr_regbank.sv
`timescale 1ns/1ps
module axr_regbank (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr,
  input  wire logic [1:0]  priv_level,
  input  wire logic [31:0] gr_rdata,
  input  wire logic [31:0] pc_value,
  output logic             instr_ready,
  output logic             instr_done,
  output logic             priv_trap,
  output logic [4:0]       gr_raddr,
  output logic             gr_wen,
  output logic [4:0]       gr_waddr,
  output logic [31:0]      gr_wdata,
  output logic             icache_en,
  output logic             dcache_en,
  output logic             burst_wr_en,
  output logic             little_endian,
  output logic             trap_step_en,
  output logic             sleep_enter,
  output logic             mult_wait,
  output logic [3:0]       icache_freeze,
  output logic [31:0]      psw_value,
  output logic [31:0]      timer_value,
  output logic             timer_load,
  output logic [31:0]      noncache_offset,
  output logic [31:0]      noncache_mask,
  output logic [31:0]      wthru_offset,
  output logic [31:0]      wthru_mask
);
  import axr_pkg::*;

  // ***************************************************************
  // Decode
  // ***************************************************************
  logic        dec_to;
  logic        dec_from;
  logic [4:0]  dec_idx;
  logic [4:0]  dec_src;
  logic [4:0]  dec_dst;
  logic        dec_wr_ok;
  logic        dec_rd_ok;
  logic        take;
  logic        privileged;
  logic [31:0] rd_word;

  axr_decode u_dec (
    .instr        (instr),
    .is_move_to   (dec_to),
    .is_move_from (dec_from),
    .aux_idx      (dec_idx),
    .gr_src       (dec_src),
    .gr_dst       (dec_dst),
    .wr_idx_ok    (dec_wr_ok),
    .rd_idx_ok    (dec_rd_ok)
  );

  axr_regs_s r;
  axr_regs_s r_nxt;

  // ***************************************************************
  // Read-back selection
  // ***************************************************************
  always_comb begin
    case (dec_idx[2:0])
      AXR_IDX_CFG: rd_word = axr_cfg_wide(r.cfg);
      AXR_IDX_PSW: rd_word = r.processor_status_word;
      AXR_IDX_TMR: rd_word = r.tmr;
      AXR_IDX_NCO: rd_word = r.nco;
      AXR_IDX_NCM: rd_word = r.ncm;
      AXR_IDX_WTO: rd_word = r.wto;
      AXR_IDX_WTM: rd_word = r.wtm;
      AXR_IDX_PCC: rd_word = r.pcc;
      default:     rd_word = 32'h00000000;
    endcase
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    r_nxt       = r;
    take        = instr_valid && r.ready;
    privileged  = priv_level == 2'h0;
    r_nxt.done  = 1'b0;
    r_nxt.trap  = 1'b0;
    r_nxt.wen   = 1'b0;
    r_nxt.sleep = 1'b0;
    r_nxt.tload = 1'b0;
    // The program counter copy is not writable; it just tracks the core
    r_nxt.pcc   = pc_value;
    case (r.st)
      AXR_ST_IDLE: begin
        if (take && (dec_to || dec_from)) begin
          if (!privileged) begin
            r_nxt.trap = 1'b1;
            r_nxt.done = 1'b1;
          end else if (dec_to) begin
            if (dec_wr_ok) begin
              // Operand fetch takes a cycle; hold off the next instruction
              r_nxt.src   = dec_src;
              r_nxt.idx   = dec_idx[2:0];
              r_nxt.st    = AXR_ST_FETCH;
              r_nxt.ready = 1'b0;
            end else begin
              r_nxt.done = 1'b1;
            end
          end else begin
            if (dec_rd_ok) begin
              r_nxt.wen   = 1'b1;
              r_nxt.waddr = dec_dst;
              r_nxt.wdata = rd_word;
            end
            r_nxt.done = 1'b1;
          end
        end
      end
      AXR_ST_FETCH: begin
        case (r.idx)
          AXR_IDX_CFG: begin
            r_nxt.cfg   = axr_cfg_fit(gr_rdata);
            r_nxt.sleep = gr_rdata[AXR_CFG_SLEEP];
          end
          AXR_IDX_PSW: r_nxt.processor_status_word = gr_rdata;
          AXR_IDX_TMR: begin
            r_nxt.tmr   = gr_rdata;
            r_nxt.tload = 1'b1;
          end
          AXR_IDX_NCO: r_nxt.nco = gr_rdata;
          AXR_IDX_NCM: r_nxt.ncm = gr_rdata;
          AXR_IDX_WTO: r_nxt.wto = gr_rdata;
          AXR_IDX_WTM: r_nxt.wtm = gr_rdata;
          default: r_nxt.done = 1'b0;
        endcase
        r_nxt.done  = 1'b1;
        r_nxt.st    = AXR_ST_IDLE;
        // Ready returns with the new value already on the outputs
        r_nxt.ready = 1'b1;
      end
      default: begin
        r_nxt.st    = AXR_ST_IDLE;
        r_nxt.ready = 1'b1;
      end
    endcase
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r.st    <= AXR_ST_IDLE;
      r.ready <= 1'b1;
      r.done  <= 1'b0;
      r.trap  <= 1'b0;
      r.src   <= 5'h00;
      r.idx   <= 3'h0;
      r.wen   <= 1'b0;
      r.waddr <= 5'h00;
      r.wdata <= 32'h00000000;
      r.cfg   <= AXR_CFG_RST;
      r.sleep <= 1'b0;
      r.processor_status_word   <= AXR_PSW_RST;
      r.tmr   <= AXR_WIN_RST;
      r.tload <= 1'b0;
      r.nco   <= AXR_WIN_RST;
      r.ncm   <= AXR_WIN_RST;
      r.wto   <= AXR_WIN_RST;
      r.wtm   <= AXR_WIN_RST;
      r.pcc   <= 32'h00000000;
    end else if (ce) begin
      r <= r_nxt;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  always_comb begin
    instr_ready     = r.ready;
    instr_done      = r.done;
    priv_trap       = r.trap;
    gr_raddr        = r.src;
    gr_wen          = r.wen;
    gr_waddr        = r.waddr;
    gr_wdata        = r.wdata;
    icache_en       = r.cfg[AXR_CFG_ICACHE];
    dcache_en       = r.cfg[AXR_CFG_DCACHE];
    burst_wr_en     = r.cfg[AXR_CFG_BURST];
    little_endian   = r.cfg[AXR_CFG_ENDIAN];
    trap_step_en    = r.cfg[AXR_CFG_TSTEP];
    sleep_enter     = r.sleep;
    mult_wait       = r.cfg[AXR_CFG_MWAIT];
    // Word bit 9 is ISA bit 22, the first quarter
    icache_freeze   = {r.cfg[AXR_CFG_FRZ_LSB], r.cfg[AXR_CFG_FRZ_LSB+1],
                       r.cfg[AXR_CFG_FRZ_LSB+2], r.cfg[AXR_CFG_FRZ_LSB+3]};
    psw_value       = r.processor_status_word;
    timer_value     = r.tmr;
    timer_load      = r.tload;
    noncache_offset = r.nco;
    noncache_mask   = r.ncm;
    wthru_offset    = r.wto;
    wthru_mask      = r.wtm;
  end
endmodule

// file: axr_regbank_props.sv
`timescale 1ns/1ps
module axr_regbank_props
  import axr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic        instr_valid,
  input wire logic [31:0] instr,
  input wire logic [1:0]  priv_level,
  input wire logic [31:0] gr_rdata,
  input wire logic        instr_ready,
  input wire logic        instr_done,
  input wire logic        priv_trap,
  input wire logic [4:0]  gr_raddr,
  input wire logic        icache_en,
  input wire logic        dcache_en,
  input wire logic        burst_wr_en,
  input wire logic        little_endian,
  input wire logic        trap_step_en,
  input wire logic        sleep_enter,
  input wire logic        mult_wait,
  input wire logic [3:0]  icache_freeze,
  input wire logic [31:0] psw_value,
  input wire logic [31:0] timer_value,
  input wire logic        timer_load
);
  // Fetch data is one cycle old when the write lands
  logic [31:0] rd_q;
  wire logic   mt = ce && instr_ready && instr_valid && instr[31:26] == AXR_OPC_DIAG
                    && instr[10:6] == AXR_SUB_MOVE_TO;
  wire logic   ok = mt && priv_level == 2'h0 && instr[25:21] <= AXR_IDX_WR_MAX;
  wire logic   cf = ok && instr[25:21] == 5'h00;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rd_q <= 32'h00000000;
    else if (ce) rd_q <= gr_rdata;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_trap_pulse: assert property (mt && priv_level != 2'h0 |=> priv_trap && instr_done)
    else $error("trap not raised");
  a_trap_kept: assert property (mt && priv_level != 2'h0 |=> $stable(psw_value) && instr_ready)
    else $error("trapped write changed state");
  a_fetch_src: assert property (ok |=> !instr_ready && gr_raddr == $past(instr[20:16]))
    else $error("wrong source fetch");
  a_write_done: assert property (ok ##1 ce |=> instr_done && instr_ready)
    else $error("write not done in time");
  a_cfg_enables: assert property (
    cf ##1 ce |=> {little_endian, burst_wr_en, dcache_en, icache_en} == rd_q[3:0])
    else $error("enable bits wrong");
  a_cfg_modes: assert property (
    cf ##1 ce |=> trap_step_en == rd_q[4] && mult_wait == rd_q[8]
    && sleep_enter == rd_q[7] && icache_freeze == {rd_q[9], rd_q[10], rd_q[11], rd_q[12]})
    else $error("mode bits wrong");
  a_psw_write: assert property (ok && instr[25:21] == 5'h01 ##1 ce |=> psw_value == rd_q)
    else $error("status word not written");
  a_timer_write: assert property (timer_load |-> instr_done && timer_value == rd_q)
    else $error("timer write wrong");
  // A low clock enable freezes the pulse, so only an enabled cycle must end it
  a_sleep_pulse: assert property (sleep_enter && ce |-> instr_done ##1 !sleep_enter)
    else $error("sleep pulse wrong");
  a_reset_clear: assert property ($rose(rstn) |-> psw_value == 32'h00000000
    && !icache_en && icache_freeze == 4'h0 && instr_ready)
    else $error("reset values wrong");
  a_cfg_hold: assert property (!instr_done |-> $stable(psw_value) && $stable(icache_freeze))
    else $error("state changed without a write");
endmodule
bind axr_regbank axr_regbank_props axr_regbank_props_i (.clk, .rstn, .ce, .instr_valid, .instr,
  .priv_level, .gr_rdata, .instr_ready, .instr_done, .priv_trap, .gr_raddr, .icache_en,
  .dcache_en, .burst_wr_en, .little_endian, .trap_step_en, .sleep_enter, .mult_wait,
  .icache_freeze, .psw_value, .timer_value, .timer_load);

// file: axr_regbank_tb.sv
`timescale 1ns/1ps
module axr_regbank_tb;
  import axr_pkg::*;
  logic        clk, rstn, ce, instr_valid, instr_ready, instr_done, priv_trap, gr_wen;
  logic        icache_en, dcache_en, burst_wr_en, little_endian, trap_step_en;
  logic        sleep_enter, mult_wait, timer_load;
  logic [31:0] instr, gr_rdata, pc_value, gr_wdata, psw_value, timer_value, w;
  logic [31:0] noncache_offset, noncache_mask, wthru_offset, wthru_mask;
  logic [31:0] gr [32];
  logic [1:0]  priv_level;
  logic [4:0]  gr_raddr, gr_waddr;
  logic [3:0]  icache_freeze;
  logic [9:0]  flags;
  int          error_cnt, compares, k;
  // General register file stands in for the core's register read port
  assign gr_rdata = gr[gr_raddr];
  assign flags = {icache_freeze, mult_wait, trap_step_en, little_endian, burst_wr_en,
                  dcache_en, icache_en};
  axr_regbank axr_regbank_i (.clk, .rstn, .ce, .instr_valid, .instr, .priv_level, .gr_rdata,
    .pc_value, .instr_ready, .instr_done, .priv_trap, .gr_raddr, .gr_wen, .gr_waddr, .gr_wdata,
    .icache_en, .dcache_en, .burst_wr_en, .little_endian, .trap_step_en, .sleep_enter,
    .mult_wait, .icache_freeze, .psw_value, .timer_value, .timer_load, .noncache_offset,
    .noncache_mask, .wthru_offset, .wthru_mask);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ***************************************************************
  // One instruction, entered at a falling edge, left in its done cycle
  // ***************************************************************
  task automatic issue(input logic [4:0] idx, input logic [4:0] sub, input logic [4:0] dst,
                       input logic [1:0] pv, input logic [31:0] data);
    int n;
    n = 0;
    gr[idx ^ 5'h10] = data;
    instr = {AXR_OPC_DIAG, idx, idx ^ 5'h10, 5'h00, sub, 1'b0, dst};
    priv_level = pv;
    instr_valid = 1'b1;
    @(posedge clk);
    @(negedge clk);
    instr_valid = 1'b0;
    while (instr_done !== 1'b1 && n < 4) begin
      n++;
      @(negedge clk);
    end
    if (instr_done !== 1'b1) begin
      chk("done wait", 32'h00000001, 32'h00000000);
      summarize();
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    instr_valid = 1'b0;
    instr = 32'h00000000;
    priv_level = 2'h0;
    pc_value = 32'h5A5A0C3C;
    error_cnt = 0;
    compares = 0;
    for (k = 0; k < 32; k++) gr[k] = 32'h00000000;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    chk("flags reset", 32'h00000000, {22'h000000, flags});
    chk("psw reset", AXR_PSW_RST, psw_value);
    $display("test reset finished");
    // High junk bits must be cut off by the 13-bit register
    for (k = 0; k < 13; k++) begin
      w = 32'hFFFFE000 | (32'h00000001 << k);
      issue(5'h00, AXR_SUB_MOVE_TO, 5'h00, 2'h0, w);
      chk("cfg flags", {22'h0, w[9], w[10], w[11], w[12], w[8], w[4:0]}, {22'h0, flags});
      chk("sleep", {31'h0, w[7]}, {31'h0, sleep_enter});
      issue(5'h00, AXR_SUB_MOVE_FROM, 5'h0B, 2'h0, 32'h00000000);
      chk("cfg read", w & 32'h00001FFF, gr_wdata);
      chk("read dst", 32'h0000002B, {26'h0, gr_wen, gr_waddr});
    end
    $display("test configuration finished");
    // A low clock enable must hold the last done pulse and refuse the offered write
    ce = 1'b0;
    gr[5'h10] = 32'h0000001F;
    instr = {AXR_OPC_DIAG, 5'h00, 5'h10, 5'h00, AXR_SUB_MOVE_TO, 1'b0, 5'h00};
    instr_valid = 1'b1;
    repeat (3) @(negedge clk);
    chk("ce frozen", 32'h00000C40, {20'h0, instr_ready, instr_done, flags});
    instr_valid = 1'b0;
    ce = 1'b1;
    @(negedge clk);
    chk("ce resumed", 32'h00000840, {20'h0, instr_ready, instr_done, flags});
    $display("test clock enable finished");
    for (k = 1; k < 7; k++) begin
      issue(5'(k), AXR_SUB_MOVE_TO, 5'h00, 2'h0, 32'hA5000000 + k);
      chk("timer load", {31'h0, k == 2}, {31'h0, timer_load});
      issue(5'(k), AXR_SUB_MOVE_FROM, 5'h02, 2'h0, 32'h00000000);
      chk("reg read", 32'hA5000000 + k, gr_wdata);
    end
    chk("psw", 32'hA5000001, psw_value);
    chk("timer", 32'hA5000002, timer_value);
    chk("nc offset", 32'hA5000003, noncache_offset);
    chk("nc mask", 32'hA5000004, noncache_mask);
    chk("wt offset", 32'hA5000005, wthru_offset);
    chk("wt mask", 32'hA5000006, wthru_mask);
    $display("test windows finished");
    for (k = 1; k < 4; k++) begin
      issue(5'h01, AXR_SUB_MOVE_TO, 5'h00, 2'(k), 32'h12345678);
      chk("trap", 32'h00000001, {31'h0, priv_trap});
      chk("psw kept", 32'hA5000001, psw_value);
    end
    issue(5'h07, AXR_SUB_MOVE_TO, 5'h00, 2'h0, 32'hFFFFFFFF);
    chk("idx7 no trap", 32'h00000000, {31'h0, priv_trap});
    chk("idx7 kept", 32'hA5000006, wthru_mask);
    issue(5'h07, AXR_SUB_MOVE_FROM, 5'h05, 2'h0, 32'h00000000);
    chk("pc copy", pc_value, gr_wdata);
    $display("test refusals finished");
    rstn = 1'b0;
    @(negedge clk);
    rstn = 1'b1;
    chk("flags reset 2", 32'h00000000, {22'h000000, flags});
    chk("psw reset 2", AXR_PSW_RST, psw_value);
    $display("test second reset finished");
    summarize();
  end
endmodule
